//--- shadow_port_pkg.sv
// Constants for the shadow receive/transmit data alias
package shadow_port_pkg;
  localparam logic [31:0] SHADOW_RX_TX_DATA_12_ADDR = 32'h5000_1060;
  localparam logic [31:0] CONTROL_ADDR = 32'h5000_1100;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1104;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_1108;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_110C;
  localparam int BYTE_MSB = 7;
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;
  localparam int LS_DATA_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_TX_EMPTY_BIT = 5;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_TXE_BIT = 2;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int FIFO_DEPTH_DEFAULT = 16;
  localparam int BAUD_DIV_DEFAULT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- shadow_rx_tx_port.sv
// Shadow receive/transmit data alias with AXI4-Lite slave and serial line
//
// Function
// - The alias at its word address reaches the receive buffer as one of sixteen 32-bit burst slots.
// - A read returns the byte received on the serial or infrared input in bits 7:0.
// - Read data is valid only while data ready is set; reads with it clear mean nothing.
// - With FIFOs off, a new character overwrites an unread buffer and flags overrun.
// - With FIFOs on, a read returns the oldest receive FIFO entry.
// - A character arriving at a full receive FIFO is dropped and flags overrun.
// - Writes to the alias go to the transmit holding path, sent on the serial or low-active infrared output.
// - With FIFOs off, a write clears transmit holding empty.
// - With FIFOs off, a further write before empty sets again replaces the held character; one in the cycle its sending starts is discarded.
// - With FIFOs on, writes are accepted up to the transmit FIFO depth, default 16.
// - A write while the transmit FIFO is full is discarded.
`timescale 1ns/1ps
`default_nettype none
module shadow_rx_tx_port
  import shadow_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEFAULT,
  parameter int BAUD_DIV = BAUD_DIV_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic SERIAL_IN,
  input wire logic IR_IN,
  output logic SERIAL_OUT,
  output logic IR_OUT_N,
  output logic IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(BAUD_DIV * 10) + 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  logic [1:0] ctrl_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  // Receive and transmit stores, one flop row per entry
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] rx_rd_r;
  logic [AW-1:0] rx_wr_r;
  logic [AW-1:0] tx_rd_r;
  logic [AW-1:0] tx_wr_r;
  logic [AW:0] rx_cnt_r;
  logic [AW:0] tx_cnt_r;
  logic overrun_r;
  logic aw_got_r;
  logic w_got_r;
  logic [31:0] aw_addr_r;
  logic [15:0] w_data_r;
  logic [1:0] w_strb_r;

  // Write channel capture, either order
  wire aw_fire = AWVALID && AWREADY;
  wire w_fire = WVALID && WREADY;
  wire wr_go = aw_got_r && w_got_r && !BVALID;
  wire hit_data_w = aw_addr_r == SHADOW_RX_TX_DATA_12_ADDR;
  wire hit_ctrl_w = aw_addr_r == CONTROL_ADDR;
  wire hit_mask_w = aw_addr_r == IRQ_MASK_ADDR;
  wire hit_ro_w = aw_addr_r == LINE_STATUS_ADDR || aw_addr_r == IRQ_STATUS_ADDR;
  wire wr_mapped = hit_data_w || hit_ctrl_w || hit_mask_w || hit_ro_w;
  wire fifo_en = ctrl_r[CTRL_FIFO_EN_BIT];
  wire ir_mode = ctrl_r[CTRL_IR_MODE_BIT];
  // byte write to transmit path; upper byte ignored
  wire tx_push_req = wr_go && hit_data_w && w_strb_r[0];
  wire tx_full = fifo_en ? (tx_cnt_r == DEPTH_C) : (tx_cnt_r != '0);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= DATA_RESET;
      w_strb_r <= '0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      AWREADY <= !aw_got_r && !aw_fire;
      WREADY <= !w_got_r && !w_fire;
      if (aw_fire) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end
      if (w_fire) begin
        w_got_r <= 1'b1;
        w_data_r <= WDATA[15:0];
        w_strb_r <= WSTRB[1:0];
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= '0;
      irq_mask_r <= '0;
    end else if (wr_go && w_strb_r[0]) begin
      if (hit_ctrl_w) ctrl_r <= w_data_r[1:0];
      if (hit_mask_w) irq_mask_r <= w_data_r[2:0];
    end
  end

  // Read channel
  logic rd_pend_r;
  logic [31:0] ar_addr_r;
  wire ar_fire = ARVALID && ARREADY;
  wire hit_data_r = ar_addr_r == SHADOW_RX_TX_DATA_12_ADDR;
  wire hit_ls_r = ar_addr_r == LINE_STATUS_ADDR;
  wire hit_irq_r = ar_addr_r == IRQ_STATUS_ADDR;
  wire rd_go = rd_pend_r && !RVALID;
  wire data_ready = rx_cnt_r != '0;
  // head of receive store; single slot uses same head
  wire [7:0] rx_head = rx_mem[rx_rd_r];
  wire tx_empty = tx_cnt_r == '0;
  wire [7:0] line_status = {2'b00, tx_empty, 3'b000, overrun_r, data_ready};
  wire rx_pop = rd_go && hit_data_r && data_ready;
  // byte in 7:0; 15:8 read zero
  wire [31:0] rd_val =
    hit_data_r ? {24'h0, rx_head} :
    hit_ls_r ? {24'h0, line_status} :
    hit_irq_r ? {29'h0, irq_st_r} :
    (ar_addr_r == CONTROL_ADDR) ? {30'h0, ctrl_r} :
    (ar_addr_r == IRQ_MASK_ADDR) ? {29'h0, irq_mask_r} : 32'h0;
  wire rd_mapped = hit_data_r || hit_ls_r || hit_irq_r || ar_addr_r == CONTROL_ADDR
    || ar_addr_r == IRQ_MASK_ADDR;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_pend_r <= 1'b0;
      ar_addr_r <= '0;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end else begin
      ARREADY <= !rd_pend_r && !ar_fire;
      if (ar_fire) begin
        rd_pend_r <= 1'b1;
        ar_addr_r <= ARADDR;
      end
      if (rd_go) begin
        RVALID <= 1'b1;
        RDATA <= rd_val;
        RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        rd_pend_r <= 1'b0;
      end
    end
  end

  // Receiver: 8N1, oversampled by BAUD_DIV
  logic [1:0] rx_sync_r;
  logic rx_busy_r;
  logic [CW-1:0] rx_tick_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  wire rx_line = ir_mode ? !IR_IN : SERIAL_IN;
  wire rx_sample = rx_busy_r && rx_tick_r == CW'(BAUD_DIV - 1);
  wire rx_done = rx_sample && rx_bit_r == 4'h9;
  wire rx_good = rx_done && rx_sync_r[1];
  wire rx_full = fifo_en ? (rx_cnt_r == DEPTH_C) : 1'b0;
  // drop when full; overwrite when FIFOs off
  wire rx_push = rx_good && !rx_full;
  wire rx_ovr = rx_good && (fifo_en ? rx_full : data_ready);
  wire rx_overwrite = rx_good && !fifo_en && data_ready;
  // Single slot sits at the read index when FIFOs are off
  wire rx_we = rx_push || rx_overwrite;
  wire [AW-1:0] rx_widx = (rx_overwrite || !fifo_en) ? rx_rd_r : rx_wr_r;
  // Occupancy steps; push and pop together leave it unchanged with FIFOs on, but drop it by one with FIFOs off
  wire rx_inc = rx_push && !rx_overwrite;
  wire rx_dec = rx_pop;

  // Receive entries, cleared so an early read shows zero
  for (genvar j = 0; j < DEPTH; j++) begin : g_rx_mem
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        rx_mem[j] <= '0;
      end else if (rx_we && rx_widx == AW'(j)) begin
        rx_mem[j] <= rx_shift_r;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_sync_r <= 2'b11;
      rx_busy_r <= 1'b0;
      rx_tick_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= '0;
    end else begin
      rx_sync_r <= {rx_sync_r[0], rx_line};
      if (!rx_busy_r) begin
        if (!rx_sync_r[1]) begin
          rx_busy_r <= 1'b1;
          rx_tick_r <= CW'(BAUD_DIV / 2);
          rx_bit_r <= '0;
        end
      end else if (rx_sample) begin
        rx_tick_r <= '0;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rx_sync_r[1]) rx_busy_r <= 1'b0;
        if (rx_bit_r != 4'h0 && rx_bit_r != 4'h9) rx_shift_r <= {rx_sync_r[1], rx_shift_r[7:1]};
        if (rx_done) rx_busy_r <= 1'b0;
      end else begin
        rx_tick_r <= rx_tick_r + CW'(1);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_rd_r <= '0;
      rx_wr_r <= '0;
      rx_cnt_r <= '0;
      overrun_r <= 1'b0;
    end else begin
      if (rx_inc) rx_wr_r <= fifo_en ? AW'(rx_wr_r + 1'b1) : rx_rd_r;
      if (rx_pop && fifo_en) rx_rd_r <= AW'(rx_rd_r + 1'b1);
      if (rx_inc && !rx_dec) rx_cnt_r <= rx_cnt_r + 1'b1;
      else if (rx_dec && !rx_inc) rx_cnt_r <= rx_cnt_r - 1'b1;
      // Overrun set wins over the read clear
      if (rx_ovr) overrun_r <= 1'b1;
      else if (rd_go && hit_ls_r) overrun_r <= 1'b0;
    end
  end

  // Transmitter
  logic tx_busy_r;
  logic [CW-1:0] tx_tick_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_shift_r;
  wire tx_start = !tx_busy_r && !tx_empty;
  wire tx_bit_end = tx_busy_r && tx_tick_r == CW'(BAUD_DIV - 1);
  // drop when full; replace when FIFOs off
  wire tx_replace = tx_push_req && !fifo_en && !tx_empty && !tx_start;
  wire tx_push = tx_push_req && (!tx_full || tx_replace);
  // Holding slot sits at the read index when FIFOs are off
  wire [AW-1:0] tx_widx = (tx_replace || !fifo_en) ? tx_rd_r : tx_wr_r;

  // Transmit entries, one write port
  for (genvar j = 0; j < DEPTH; j++) begin : g_tx_mem
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        tx_mem[j] <= '0;
      end else if (tx_push && tx_widx == AW'(j)) begin
        tx_mem[j] <= w_data_r[BYTE_MSB:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_rd_r <= '0;
      tx_wr_r <= '0;
      tx_cnt_r <= '0;
      tx_busy_r <= 1'b0;
      tx_tick_r <= '0;
      tx_bit_r <= '0;
      tx_shift_r <= '1;
      SERIAL_OUT <= 1'b1;
      IR_OUT_N <= 1'b1;
    end else begin
      // accept up to DEPTH; holding fills, empty clears
      if (tx_push && !tx_replace) tx_wr_r <= fifo_en ? AW'(tx_wr_r + 1'b1) : tx_rd_r;
      if (tx_start) tx_rd_r <= fifo_en ? AW'(tx_rd_r + 1'b1) : tx_rd_r;
      if (tx_push && !tx_replace && !tx_start) tx_cnt_r <= tx_cnt_r + 1'b1;
      else if (tx_start && !(tx_push && !tx_replace)) tx_cnt_r <= tx_cnt_r - 1'b1;
      if (tx_start) begin
        tx_busy_r <= 1'b1;
        tx_shift_r <= {1'b1, tx_mem[tx_rd_r], 1'b0};
        tx_tick_r <= '0;
        tx_bit_r <= '0;
      end else if (tx_bit_end) begin
        tx_tick_r <= '0;
        tx_shift_r <= {1'b1, tx_shift_r[9:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_bit_r == 4'h9) tx_busy_r <= 1'b0;
      end else if (tx_busy_r) begin
        tx_tick_r <= tx_tick_r + CW'(1);
      end
      // serial or low-active infrared pulse in first half of zero bits
      SERIAL_OUT <= ir_mode ? 1'b1 : (tx_busy_r ? tx_shift_r[0] : 1'b1);
      IR_OUT_N <= ir_mode && tx_busy_r && !tx_shift_r[0] ? (tx_tick_r >= CW'(BAUD_DIV / 2)) : 1'b1;
    end
  end

  // Interrupts: sticky, read-clear, set wins
  wire [2:0] irq_ev = {tx_start && tx_cnt_r == (AW + 1)'(1), rx_ovr, rx_push};
  wire irq_rd = rd_go && hit_irq_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_st_r <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_st_r <= irq_ev | (irq_rd ? 3'h0 : irq_st_r);
      IRQ <= |(irq_st_r & irq_mask_r);
    end
  end
endmodule
`default_nettype wire

//--- shadow_port_monitor.sv
// Bus and line checker for the shadow data port
`timescale 1ns/1ps
`default_nettype none
module shadow_port_monitor #(
  parameter int BAUD_DIV = 4
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic SERIAL_OUT,
  input wire logic IR_OUT_N
);
  int low_r;
  // Cycles the serial output has been low
  always_ff @(posedge CLOCK or negedge RST_N)
    if (!RST_N) low_r <= 0;
    else low_r <= SERIAL_OUT ? 0 : low_r + 1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  hi_byte_a: assert property (RVALID |-> RDATA[15:8] == 8'h00) else $error("upper byte set");
  rd_answer_a: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID) else $error("late read");
  ar_drop_a: assert property (ARVALID && ARREADY |=> !ARREADY) else $error("second read taken");
  rd_done_a: assert property (RVALID && RREADY |=> !RVALID) else $error("read answer repeated");
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("late write");
  wr_done_a: assert property (BVALID && BREADY |=> !BVALID) else $error("write answer repeated");
  bit_time_a: assert property ($rose(SERIAL_OUT) |-> low_r % BAUD_DIV == 0) else $error("bad bit time");
  // Half bit at a divider of four
  ir_pulse_a: assert property ($fell(IR_OUT_N) |=> !IR_OUT_N ##1 IR_OUT_N) else $error("bad pulse");
  cover property (ARVALID && ARREADY);
  cover property (BVALID && BREADY);
  cover property ($fell(IR_OUT_N));
endmodule
bind shadow_rx_tx_port shadow_port_monitor #(.BAUD_DIV(BAUD_DIV)) mon (.*);
`default_nettype wire

//--- remote_uart_model.sv
// Remote serial partner that sends and captures 8N1 frames
`timescale 1ns/1ps
`default_nettype none
module remote_uart_model #(
  parameter int BAUD = 4
) (
  input wire logic CLOCK,
  output logic TXD = 1'b1,
  output logic IR_TXD = 1'b0,
  input wire logic RXD,
  input wire logic IR_RXD_N
);
  logic [7:0] got[$];
  logic [7:0] sh;
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLOCK);
      TXD <= ir | f[i];
      IR_TXD <= ir & ~f[i];
      repeat (BAUD / 2) @(posedge CLOCK);
      repeat (BAUD / 2 - 1) @(posedge CLOCK);
    end
  endtask
  // line level is both outputs together
  initial forever begin
    @(negedge CLOCK iff ((RXD & IR_RXD_N) === 1'b0));
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD) @(negedge CLOCK);
      sh[i] = RXD & IR_RXD_N;
    end
    got.push_back(sh);
    repeat (BAUD) @(negedge CLOCK);
  end
endmodule
`default_nettype wire

//--- tb_shadow_rx_tx_port.sv
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
`default_nettype none
module tb_shadow_rx_tx_port
  import shadow_port_pkg::*;
;
  localparam int D = 4;
  localparam logic [31:0] DAT = SHADOW_RX_TX_DATA_12_ADDR;
  localparam logic [31:0] LS = LINE_STATUS_ADDR;
  logic CLOCK = 1'b0, RST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, d;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] BRESP, RRESP, rsp;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SERIAL_IN, IR_IN, SERIAL_OUT, IR_OUT_N, IRQ;
  int err_count = 0, checked = 0, cyc = 0;
  shadow_rx_tx_port #(.DEPTH(D), .BAUD_DIV(4)) dut (.*);
  remote_uart_model #(.BAUD(4)) model (.CLOCK(CLOCK), .TXD(SERIAL_IN), .IR_TXD(IR_IN), .RXD(SERIAL_OUT),
    .IR_RXD_N(IR_OUT_N));
  initial forever #2 CLOCK = ~CLOCK;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic aw_left, w_left, aw_take, w_take;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw_left || w_left) begin
      @(negedge CLOCK);
      aw_take = aw_left && AWREADY === 1'b1;
      w_take = w_left && WREADY === 1'b1;
      @(posedge CLOCK);
      if (aw_take) AWVALID <= 1'b0;
      if (w_take) WVALID <= 1'b0;
      aw_left = aw_left && !aw_take;
      w_left = w_left && !w_take;
    end
    @(negedge CLOCK);
    while (BVALID !== 1'b1) @(negedge CLOCK);
    rsp = BRESP;
    @(posedge CLOCK);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    @(negedge CLOCK);
    while (ARREADY !== 1'b1) @(negedge CLOCK);
    @(posedge CLOCK);
    ARVALID <= 1'b0;
    @(negedge CLOCK);
    while (RVALID !== 1'b1) @(negedge CLOCK);
    d = RDATA;
    rsp = RRESP;
    @(posedge CLOCK);
    RREADY <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic waitn(input int n);
    for (int i = 0; i < 3000 && model.got.size() < n; i++) @(posedge CLOCK);
    repeat (60) @(posedge CLOCK);
  endtask
  task automatic t_reset;
    rc(DAT, 32'h0);
    rc(LS, 32'h20);
    rc(32'h5000_1200, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(32'h5000_1200, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("reset test end");
  endtask
  task automatic t_rx_off;
    wr(CONTROL_ADDR, 32'h0);
    wr(IRQ_MASK_ADDR, 32'h2);
    model.send(8'hA5, 1'b0);
    repeat (8) @(posedge CLOCK);
    chk(32'(IRQ), 32'h0);
    model.send(8'h3C, 1'b0);
    repeat (8) @(posedge CLOCK);
    chk(32'(IRQ), 32'h1);
    rc(IRQ_STATUS_ADDR, 32'h3);
    repeat (2) @(posedge CLOCK);
    chk(32'(IRQ), 32'h0);
    rc(LS, 32'h23);
    rc(DAT, 32'h3C);
    rc(LS, 32'h20);
    $display("receive direct end");
  endtask
  task automatic t_rx_fifo;
    wr(CONTROL_ADDR, 32'h1);
    for (int i = 0; i <= D; i++) model.send(8'h40 + 8'(i), 1'b0);
    repeat (8) @(posedge CLOCK);
    rc(LS, 32'h23);
    for (int i = 0; i < D; i++) rc(DAT, 32'h40 + i);
    rc(LS, 32'h20);
    $display("receive queue end");
  endtask
  task automatic t_ir;
    wr(CONTROL_ADDR, 32'h2);
    model.send(8'h96, 1'b1);
    repeat (8) @(posedge CLOCK);
    rc(DAT, 32'h96);
    wr(DAT, 32'h5A);
    waitn(1);
    chk(32'(model.got.size()), 32'h1);
    chk(32'(model.got[0]), 32'h5A);
    model.got.delete();
    $display("infrared end");
  endtask
  task automatic t_tx_off;
    wr(CONTROL_ADDR, 32'h0);
    wr(DAT, 32'hFF81);
    wr(DAT, 32'h0042);
    rc(LS, 32'h0);
    wr(DAT, 32'h0043);
    waitn(2);
    chk(32'(model.got.size()), 32'h2);
    chk(32'(model.got[0]), 32'h81);
    chk(32'(model.got[1]), 32'h43);
    rc(LS, 32'h20);
    model.got.delete();
    $display("transmit direct end");
  endtask
  task automatic t_tx_fifo;
    wr(CONTROL_ADDR, 32'h1);
    rc(LS, 32'h20);
    for (int i = 0; i < D + 2; i++) wr(DAT, 32'h60 + i);
    waitn(D + 2);
    chk(32'(model.got.size()), 32'(D + 1));
    for (int i = 0; i <= D; i++) chk(32'(model.got[i]), 32'h60 + i);
    rc(IRQ_STATUS_ADDR, 32'h7);
    $display("transmit queue end");
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    t_reset;
    t_rx_off;
    t_rx_fifo;
    t_ir;
    t_tx_off;
    t_tx_fifo;
    conclude;
  end
endmodule
`default_nettype wire
